// ### comparator_one_input_select.sv
// Comparator-one input select register with decoded analog routing
//
// Summary of operation
// - Register sits at special-function address 0x9E, page 0x0, fully read/write.
// - Reset sets all eight bits to one: ground negative, MCU supply positive.
// - Bits 7:4 pick negative input: port pins, digital supply, ground; some reserved.
// - Bits 3:0 pick positive input: port pins, battery, MCU supply; some reserved.
// - Code 1100 in either field routes the touch-sense reference level.
// - Code 1101 in either field routes half the MCU supply.
`include "comparator_one_cfg.svh"

module comparator_one_input_select #(
   parameter int CODE_WIDTH = 4
) (
   input wire logic clk,
   input wire logic rstn,
   // Special-function register access from the core
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   // Raw select fields
   output logic [3:0] negative_input_code,
   output logic [3:0] positive_input_code,
   // Negative multiplexer routes
   output logic [3:0] neg_port0_sel,
   output logic [1:0] neg_port1_sel,
   output logic [2:0] neg_port2_sel,
   output logic neg_touch_ref_sel,
   output logic neg_half_supply_sel,
   output logic neg_digital_supply_sel,
   output logic neg_ground_sel,
   output logic neg_reserved,
   // Positive multiplexer routes
   output logic [3:0] pos_port0_sel,
   output logic pos_port1_sel,
   output logic [3:0] pos_port2_sel,
   output logic pos_touch_ref_sel,
   output logic pos_half_supply_sel,
   output logic pos_battery_sel,
   output logic pos_mcu_supply_sel,
   output logic pos_reserved,
   // Shared analog resources
   output logic divider_enable,
   output logic touch_ref_enable,
   // Per-pin analog use, for the port logic
   output logic [7:0] port0_analog,
   output logic [7:0] port1_analog,
   output logic [7:0] port2_analog
);
   comparator_one_pkg::sfr_byte_t select;
   comparator_one_pkg::sfr_byte_t next_select;
   comparator_one_pkg::sfr_byte_t next_rdata;
   comparator_one_pkg::input_code_t next_neg_code;
   comparator_one_pkg::input_code_t next_pos_code;
   comparator_one_pkg::route_vec_t neg_route;
   comparator_one_pkg::route_vec_t pos_route;
   logic next_divider_enable;
   logic next_touch_ref_enable;
   logic reg_hit;

   localparam logic [7:0] RESET_VALUE = `CMP1_SEL_RESET;
   localparam logic [15:0] NEG_RESERVED = `CMP1_NEG_RESERVED_MASK;
   localparam logic [15:0] POS_RESERVED = `CMP1_POS_RESERVED_MASK;

   // Elaboration checks on the field layout and code tables
   generate
      if (CODE_WIDTH != 4) begin : g_bad_width
         $error("comparator_one_input_select: select fields are 4 bits wide");
      end
      if (`CMP1_NEG_MSB - `CMP1_NEG_LSB + 1 != CODE_WIDTH) begin : g_neg_field
         $error("comparator_one_input_select: negative field width mismatch");
      end
      if (`CMP1_POS_MSB - `CMP1_POS_LSB + 1 != CODE_WIDTH) begin : g_pos_field
         $error("comparator_one_input_select: positive field width mismatch");
      end
      if (RESET_VALUE[`CMP1_NEG_MSB:`CMP1_NEG_LSB] != `CMP1_CODE_NEG_GROUND) begin : g_neg_reset
         $error("comparator_one_input_select: negative reset code must be ground");
      end
      if (RESET_VALUE[`CMP1_POS_MSB:`CMP1_POS_LSB] != `CMP1_CODE_POS_MCU) begin : g_pos_reset
         $error("comparator_one_input_select: positive reset code must be MCU supply");
      end
      // Touch reference and divider codes must route on both sides
      if (NEG_RESERVED[`CMP1_CODE_TOUCH_REF] || NEG_RESERVED[`CMP1_CODE_HALF_SUPPLY]
         || POS_RESERVED[`CMP1_CODE_TOUCH_REF] || POS_RESERVED[`CMP1_CODE_HALF_SUPPLY])
      begin : g_shared
         $error("comparator_one_input_select: shared codes must not be reserved");
      end
   endgenerate

   // Address and page decode
   assign reg_hit = (sfr_addr == `CMP1_SEL_ADDR) && (sfr_page == `CMP1_SEL_PAGE);
   // Core muxes read data on this, so idle read data stays zero
   assign sfr_hit = reg_hit;

   // Register write and read-back
   always_comb begin
      next_select = select;
      if (sfr_wr && reg_hit) begin
         next_select = sfr_wdata;
      end
      // Read sees the value held before a same-cycle write
      next_rdata = 8'h00;
      if (sfr_rd && reg_hit) begin
         next_rdata = select;
      end
   end

   // Reserved codes are kept as written; only the decode ignores them
   always_ff @(posedge clk) begin
      if (!rstn) begin
         select <= `CMP1_SEL_RESET;
         sfr_rdata <= 8'h00;
      end else begin
         select <= next_select;
         sfr_rdata <= next_rdata;
      end
   end

   // Raw fields come straight from the register
   assign negative_input_code = select[`CMP1_NEG_MSB:`CMP1_NEG_LSB];
   assign positive_input_code = select[`CMP1_POS_MSB:`CMP1_POS_LSB];

   // Decode follows the next value so routes change with the register
   assign next_neg_code = next_select[`CMP1_NEG_MSB:`CMP1_NEG_LSB];
   assign next_pos_code = next_select[`CMP1_POS_MSB:`CMP1_POS_LSB];

   // Each side has its own set of reserved codes
   input_route_decoder #(
      .RESERVED_MASK(`CMP1_NEG_RESERVED_MASK),
      .RESET_CODE(`CMP1_CODE_NEG_GROUND)
   ) u_neg_decoder (
      .clk(clk),
      .rstn(rstn),
      .code(next_neg_code),
      .route(neg_route),
      .reserved(neg_reserved)
   );

   input_route_decoder #(
      .RESERVED_MASK(`CMP1_POS_RESERVED_MASK),
      .RESET_CODE(`CMP1_CODE_POS_MCU)
   ) u_pos_decoder (
      .clk(clk),
      .rstn(rstn),
      .code(next_pos_code),
      .route(pos_route),
      .reserved(pos_reserved)
   );

   // Negative side: port0 bits 1,3,5,7; port1 bits 5,7; port2 bits 1,3,5
   assign neg_port0_sel = neg_route[3:0];
   assign neg_port1_sel = neg_route[7:6];
   assign neg_port2_sel = neg_route[10:8];
   assign neg_touch_ref_sel = neg_route[`CMP1_CODE_TOUCH_REF];
   assign neg_half_supply_sel = neg_route[`CMP1_CODE_HALF_SUPPLY];
   assign neg_digital_supply_sel = neg_route[`CMP1_CODE_NEG_DIGITAL];
   assign neg_ground_sel = neg_route[`CMP1_CODE_NEG_GROUND];

   // Positive side: port0 bits 0,2,4,6; port1 bit 6; port2 bits 0,2,4,6
   assign pos_port0_sel = pos_route[3:0];
   assign pos_port1_sel = pos_route[7];
   assign pos_port2_sel = pos_route[11:8];
   assign pos_touch_ref_sel = pos_route[`CMP1_CODE_TOUCH_REF];
   assign pos_half_supply_sel = pos_route[`CMP1_CODE_HALF_SUPPLY];
   assign pos_battery_sel = pos_route[`CMP1_CODE_POS_BATTERY];
   assign pos_mcu_supply_sel = pos_route[`CMP1_CODE_POS_MCU];

   // Divider draws current only while either side selects it
   always_comb begin
      next_divider_enable = (next_neg_code == `CMP1_CODE_HALF_SUPPLY)
         || (next_pos_code == `CMP1_CODE_HALF_SUPPLY);
      next_touch_ref_enable = (next_neg_code == `CMP1_CODE_TOUCH_REF)
         || (next_pos_code == `CMP1_CODE_TOUCH_REF);
   end

   // Enables switch on the same edge as the routes they feed
   always_ff @(posedge clk) begin
      if (!rstn) begin
         divider_enable <= 1'b0;
         touch_ref_enable <= 1'b0;
      end else begin
         divider_enable <= next_divider_enable;
         touch_ref_enable <= next_touch_ref_enable;
      end
   end

   // Pin maps: even pins positive, odd pins negative
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1) begin : g_pin
         if (k % 2 == 0) begin : g_even
            assign port0_analog[k] = pos_route[k / 2];
            assign port2_analog[k] = pos_route[8 + k / 2];
            // Only pin 6 of port1 reaches the positive side
            if (k == 6) begin : g_port1
               assign port1_analog[k] = pos_route[7];
            end else begin : g_port1_none
               assign port1_analog[k] = 1'b0;
            end
         end else begin : g_odd
            assign port0_analog[k] = neg_route[k / 2];
            // Port2 pin 7 has no negative code
            if (k < 7) begin : g_port2
               assign port2_analog[k] = neg_route[8 + k / 2];
            end else begin : g_port2_none
               assign port2_analog[k] = 1'b0;
            end
            // Port1 pins 5 and 7 take negative codes 6 and 7
            if (k >= 5) begin : g_port1
               assign port1_analog[k] = neg_route[6 + (k - 5) / 2];
            end else begin : g_port1_none
               assign port1_analog[k] = 1'b0;
            end
         end
      end
   endgenerate
endmodule

// ### comparator_one_cfg.svh
// Address, field and code constants for the comparator-one input select register
`ifndef COMPARATOR_ONE_CFG_SVH
`define COMPARATOR_ONE_CFG_SVH

`define CMP1_SEL_ADDR 8'h9E
`define CMP1_SEL_PAGE 8'h00
`define CMP1_SEL_RESET 8'hFF

`define CMP1_NEG_MSB 7
`define CMP1_NEG_LSB 4
`define CMP1_POS_MSB 3
`define CMP1_POS_LSB 0

`define CMP1_CODE_TOUCH_REF 4'hC
`define CMP1_CODE_HALF_SUPPLY 4'hD
`define CMP1_CODE_NEG_DIGITAL 4'hE
`define CMP1_CODE_NEG_GROUND 4'hF
`define CMP1_CODE_POS_BATTERY 4'hE
`define CMP1_CODE_POS_MCU 4'hF

`define CMP1_NEG_RESERVED_MASK 16'h0830
`define CMP1_POS_RESERVED_MASK 16'h0070

`endif

// ### comparator_one_pkg.sv
// Types shared by the comparator-one input select logic
package comparator_one_pkg;
   typedef logic [3:0] input_code_t;
   typedef logic [15:0] route_vec_t;
   typedef logic [7:0] sfr_byte_t;
endpackage

// ### input_route_decoder.sv
// Registered one-hot decode of one comparator input select code
module input_route_decoder #(
   parameter logic [15:0] RESERVED_MASK = 16'h0000,
   parameter logic [3:0] RESET_CODE = 4'hF
) (
   input wire logic clk,
   input wire logic rstn,
   input wire comparator_one_pkg::input_code_t code,
   output comparator_one_pkg::route_vec_t route,
   output logic reserved
);
   comparator_one_pkg::route_vec_t next_route;
   logic next_reserved;

   generate
      if (RESERVED_MASK[RESET_CODE]) begin : g_bad_reset
         $error("input_route_decoder: reset code must not be reserved");
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_entry
         // Reserved codes route nothing
         assign next_route[i] = (code == 4'(i)) && !RESERVED_MASK[i];
      end
   endgenerate

   always_comb begin
      next_reserved = RESERVED_MASK[code];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         route <= 16'h0001 << RESET_CODE;
         reserved <= RESERVED_MASK[RESET_CODE];
      end else begin
         route <= next_route;
         reserved <= next_reserved;
      end
   end
endmodule

// ### comparator_one_asserts.sv
// Concurrent checks on the comparator-one input select register
module comparator_one_asserts (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   input wire logic [3:0] negative_input_code,
   input wire logic [3:0] positive_input_code,
   input wire logic neg_ground_sel,
   input wire logic neg_reserved,
   input wire logic pos_mcu_supply_sel,
   input wire logic pos_battery_sel,
   input wire logic pos_reserved,
   input wire logic divider_enable,
   input wire logic touch_ref_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] n;
   logic [3:0] p;
   assign n = negative_input_code;
   assign p = positive_input_code;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_wr;
      sfr_wr && sfr_hit;
   endsequence
   AST_RESET: assert property (disable iff (1'b0) !rstn |=> {n, p} == 8'hFF)
      else $error("reset value wrong");
   AST_WRITE: assert property (s_wr |=> {n, p} == $past(sfr_wdata))
      else $error("write not taken");
   AST_HOLD: assert property (!(sfr_wr && sfr_hit) |=> $stable({n, p}))
      else $error("register changed without write");
   AST_READ: assert property (sfr_rd && sfr_hit |=> sfr_rdata == $past({n, p}))
      else $error("read data wrong");
   AST_MISS: assert property (!(sfr_rd && sfr_hit) |=> sfr_rdata == 8'h00)
      else $error("read data not idle");
   AST_HIT: assert property (sfr_hit == (sfr_addr == 8'h9E && sfr_page == 8'h00))
      else $error("decode wrong");
   AST_NEG: assert property (neg_ground_sel == (n == 4'hF) && neg_reserved == (n inside {4'h4, 4'h5, 4'hB}))
      else $error("negative decode wrong");
   AST_POS: assert property (pos_battery_sel == (p == 4'hE) && pos_mcu_supply_sel == (p == 4'hF)
      && pos_reserved == (p inside {4'h4, 4'h5, 4'h6}))
      else $error("positive decode wrong");
   AST_TOUCH: assert property (touch_ref_enable == (n == 4'hC || p == 4'hC))
      else $error("touch reference wrong");
   AST_HALF: assert property (divider_enable == (n == 4'hD || p == 4'hD))
      else $error("divider wrong");
endmodule

bind comparator_one_input_select comparator_one_asserts i_chk (.clk, .rstn, .sfr_addr,
   .sfr_page, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit, .negative_input_code,
   .positive_input_code, .neg_ground_sel, .neg_reserved, .pos_mcu_supply_sel,
   .pos_battery_sel, .pos_reserved, .divider_enable, .touch_ref_enable);

// ### comparator_one_input_select_tb.sv
// Self-checking bench for the comparator-one input select register
module comparator_one_input_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_page = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata, port0_analog, port1_analog, port2_analog, flags;
   logic sfr_hit, dv, tr, nr, pr, ng, pm, pb, nd, nt, nh, pt, ph, p1;
   logic [3:0] nc, pc, n0, p0, p2;
   logic [1:0] n1;
   logic [2:0] n2;
   logic [15:0] neg_vec, pos_vec, exp_neg, exp_pos;
   logic [7:0] exp_pin;
   int fail_count = 0;
   int checks_done = 0;
   assign flags = {dv, tr, nr, pr, ng, pm, pb, nd};
   // Route outputs gathered in code order, one bit per field code
   assign neg_vec = {ng, nd, nh, nt, 1'b0, n2, n1, 2'b00, n0};
   assign pos_vec = {pm, pb, ph, pt, p2, p1, 3'b000, p0};
   comparator_one_input_select i_dut (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
      .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .negative_input_code(nc),
      .positive_input_code(pc), .neg_port0_sel(n0), .neg_port1_sel(n1), .neg_port2_sel(n2),
      .neg_touch_ref_sel(nt), .neg_half_supply_sel(nh), .neg_digital_supply_sel(nd),
      .neg_ground_sel(ng), .neg_reserved(nr), .pos_port0_sel(p0), .pos_port1_sel(p1),
      .pos_port2_sel(p2), .pos_touch_ref_sel(pt), .pos_half_supply_sel(ph),
      .pos_battery_sel(pb), .pos_mcu_supply_sel(pm), .pos_reserved(pr),
      .divider_enable(dv), .touch_ref_enable(tr), .port0_analog(port0_analog),
      .port1_analog(port1_analog), .port2_analog(port2_analog));
   initial forever #20 clk = ~clk;
   task automatic test_done;
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One access cycle; strobes stay up until the next call replaces them
   task automatic acc(input logic [15:0] pa, input logic w, input logic r,
      input logic [7:0] d, input logic [7:0] exp);
      {sfr_page, sfr_addr} = pa;
      sfr_wdata = d;
      sfr_wr = w;
      sfr_rd = r;
      @(negedge clk);
      check({7'h00, sfr_hit}, {7'h00, pa == 16'h009E});
      if (r)
         check(sfr_rdata, exp);
   endtask
   initial begin
      #20us;
      fail_count++;
      test_done;
   end
   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      acc(16'h009E, 1'b0, 1'b1, 8'h00, 8'hFF);
      check({nc, pc}, 8'hFF);
      check(flags, 8'h0C);
      acc(16'h009F, 1'b1, 1'b0, 8'h12, 8'h00);
      acc(16'h019E, 1'b1, 1'b0, 8'h34, 8'h00);
      acc(16'h009F, 1'b0, 1'b1, 8'h00, 8'h00);
      acc(16'h009E, 1'b0, 1'b1, 8'h00, 8'hFF);
      for (int k = 0; k < 16; k++) begin
         acc(16'h009E, 1'b1, 1'b0, {k[3:0], k[3:0]}, 8'h00);
         check({nc, pc}, {k[3:0], k[3:0]});
         acc(16'h009E, 1'b0, 1'b1, 8'h00, {k[3:0], k[3:0]});
         exp_neg = k inside {4, 5, 11} ? 16'h0000 : 16'h0001 << k;
         exp_pos = k inside {4, 5, 6} ? 16'h0000 : 16'h0001 << k;
         check(neg_vec[15:8], exp_neg[15:8]);
         check(neg_vec[7:0], exp_neg[7:0]);
         check(pos_vec[15:8], exp_pos[15:8]);
         check(pos_vec[7:0], exp_pos[7:0]);
         check(port0_analog, k < 4 ? 8'h03 << (2 * k) : 8'h00);
         check(port1_analog, k == 7 ? 8'hC0 : k == 6 ? 8'h20 : 8'h00);
         exp_pin = (k > 7 && k < 11) ? 8'h03 << (2 * (k - 8)) : k == 11 ? 8'h40 : 8'h00;
         check(port2_analog, exp_pin);
         exp_pin = {k == 13, k == 12, k inside {4, 5, 11}, k inside {4, 5, 6}, 4'h0};
         exp_pin[3:0] = {k == 15, k == 15, k == 14, k == 14};
         check(flags, exp_pin);
      end
      acc(16'h009E, 1'b1, 1'b0, 8'hCD, 8'h00);
      check(flags, 8'hC0);
      check(neg_vec[15:8], 8'h10);
      check(pos_vec[15:8], 8'h20);
      acc(16'h009E, 1'b1, 1'b0, 8'hF5, 8'h00);
      check(flags, 8'h18);
      acc(16'h009E, 1'b1, 1'b1, 8'hA7, 8'hF5);
      check(port1_analog, 8'h40);
      check(port2_analog, 8'h20);
      acc(16'h009E, 1'b1, 1'b1, 8'h5C, 8'hA7);
      acc(16'h009E, 1'b0, 1'b1, 8'h00, 8'h5C);
      check(flags, 8'h60);
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
      acc(16'h009E, 1'b0, 1'b1, 8'h00, 8'hFF);
      check({nc, pc}, 8'hFF);
      check(flags, 8'h0C);
      test_done;
   end
endmodule
